// ==== design/mmcd_pkg.sv ====
// constants and carrier types of the per-axis command decoder
// assumes one clock domain and four axes sharing one register slave
package mmcd_pkg;

  // ----------
  // sizes
  // ----------
  localparam int NAX = 4;
  localparam int NSYNC = 4;
  localparam int SPW = 24;
  localparam int TW = 32;
  localparam int PW = 16;
  localparam int AW = 6;

  // ----------
  // register byte offsets
  // ----------
  localparam logic [AW-1:0] OFF_CMD = 6'h00;
  localparam logic [AW-1:0] OFF_CFG = 6'h04;
  localparam logic [AW-1:0] OFF_STEP = 6'h08;
  localparam logic [AW-1:0] OFF_TLIM = 6'h0c;
  localparam logic [AW-1:0] OFF_DCC = 6'h10;
  localparam logic [AW-1:0] OFF_SPLIT = 6'h14;
  localparam logic [AW-1:0] OFF_AXSEL = 6'h18;
  localparam logic [AW-1:0] OFF_MAIN = 6'h20;
  localparam logic [AW-1:0] OFF_ERRFIN = 6'h24;
  localparam logic [AW-1:0] OFF_PAGED = 6'h28;
  localparam logic [AW-1:0] OFF_SPEED = 6'h2c;
  localparam logic [AW-1:0] OFF_TCNT = 6'h30;

  // ----------
  // command codes and field positions
  // ----------
  localparam logic [3:0] OP_SYNC_EN = 4'h8;
  localparam logic [3:0] OP_SYNC_DIS = 4'h9;
  localparam logic [3:0] OP_SYNC_ACT = 4'ha;
  localparam logic [7:0] CMD_SPD_UP = 8'h70;
  localparam logic [7:0] CMD_SPD_DN = 8'h71;
  localparam logic [7:0] CMD_DCC = 8'h72;
  localparam logic [7:0] CMD_TMR_START = 8'h73;
  localparam logic [7:0] CMD_TMR_STOP = 8'h74;
  localparam logic [7:0] CMD_SPL_START = 8'h75;
  localparam logic [7:0] CMD_SPL_END = 8'h76;
  localparam logic [7:0] CMD_HOLD = 8'h77;
  localparam logic [7:0] CMD_RELEASE = 8'h78;
  localparam logic [7:0] CMD_STS_CLR = 8'h79;
  localparam logic [7:0] CMD_PAGE0 = 8'h7a;
  localparam logic [7:0] CMD_PAGE1 = 8'h7b;
  localparam int CMD_AXIS_LSB = 8;
  localparam int CFG_ERROR_SYNC_DISABLE_BIT_BIT = 7;
  localparam int CFG_TRI_BIT = 13;
  localparam int CFG_TIMER_REPEAT_BIT_BIT = 14;
  localparam int DCC_LEVEL_BIT = 16;
  localparam int PG_PAGE_BIT = 15;
  localparam int PG_CONSTANT_SPEED_FLAG_BIT = 5;
  localparam int PG_SPLIT_BIT = 4;
  localparam int PG0_TRUN_BIT = 0;
  localparam int MAIN_ERR_LSB = 4;
  localparam int EF_FIN_LSB = 8;

  // ----------
  // reset values
  // ----------
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DCC_RST = 32'h0000_0008;
  localparam logic [31:0] SPLIT_RST = 32'h0010_0008;
  localparam logic [SPW-1:0] STEP_RST = 24'h00_0001;
  localparam logic [TW-1:0] TLIM_RST = 32'h0000_ffff;

  // ----------
  // carriers
  // ----------
  typedef struct packed {
    logic driving;
    logic interp;
    logic constant_speed_flag;
    logic drive_req;
    logic err_evt;
    logic [7:0] err_info;
    logic fin_evt;
    logic [3:0] fin_code;
    logic [NSYNC-1:0] sync_factor;
    logic [SPW-1:0] drive_speed;
  } mmcd_axis_in_t;

  typedef struct packed {
    logic [NSYNC-1:0] sync_fire;
    logic drive_start;
    logic [SPW-1:0] speed;
    logic dcc_pin;
    logic split_pin;
    logic timer_up;
  } mmcd_axis_out_t;

  typedef struct packed {
    logic [NSYNC-1:0] sync_en;
    logic [NSYNC-1:0] fire;
    logic err;
    logic [7:0] info;
    logic [3:0] fin;
    logic page;
    logic hold;
    logic pend;
    logic start;
    logic [SPW-1:0] speed;
    logic [PW-1:0] dcc_cnt;
    logic dcc_on;
    logic split_act;
    logic [PW-1:0] spl_cnt;
    logic spl_pin;
  } mmcd_axstate_t;

  typedef struct packed {
    mmcd_axstate_t [NAX-1:0] ax;
    logic [31:0] cfg;
    logic [SPW-1:0] step;
    logic [TW-1:0] tlim;
    logic [31:0] dcc_cfg;
    logic [31:0] spl_cfg;
    logic [1:0] axsel;
    logic wait_q;
    logic [31:0] rdata;
  } mmcd_state_t;

endpackage : mmcd_pkg

// ==== design/mmcd_timer.sv ====
// per-axis up-counting timer with one-shot or repeat expiry
// assumes start and stop are single-cycle pulses from the decoder
`timescale 1ns/1ns
module mmcd_timer #(
  parameter int TW = mmcd_pkg::TW
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic repeat_i,
  input wire logic [TW-1:0] limit_i,
  output logic [TW-1:0] count_o,
  output logic running_o,
  output logic up_o
);

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic run;
    logic up;
  } mmcd_tmr_t;

  mmcd_tmr_t s_q;
  mmcd_tmr_t s_d;

  // ----------
  // next state
  // ----------
  always_comb begin
    s_d = s_q;
    s_d.up = 1'b0;
    if (start_i) begin
      s_d.cnt = '0; // (R15)
      s_d.run = 1'b1;
    end else if (stop_i) begin
      s_d.cnt = '0; // (R17)
      s_d.run = 1'b0;
    end else if (s_q.run) begin
      if (s_q.cnt >= limit_i) begin
        s_d.up = 1'b1; // (R15)
        s_d.cnt = '0;
        s_d.run = repeat_i; // (R16)
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.cnt;
  assign running_o = s_q.run;
  assign up_o = s_q.up;

endmodule : mmcd_timer

// ==== design/mmcd_decoder.sv ====
// data-less command decoder for four axes, with avalon-mm register slave
// assumes axis inputs are synchronous to mclk_i and event inputs are pulses
//
// Notes on behaviour
// (R1) disable mask in low nibble clears sets
// (R2) disabled sets never fire
// (R3) reset leaves all sync sets disabled
// (R4) set enables readable on status page 1
// (R5) activate mask fires selected sets at once
// (R6) host configures and enables before activating
// (R7) enable refused when error_sync_disable_bit set and error
// (R8) host waits access time between commands
// (R9) speed up adds step while driving
// (R10) speed down subtracts step while driving
// (R11) speed change only at constant speed
// (R12) setting untouched, ignored when interpolating
// (R13) host disables triangle prevention for fixed
// (R14) deviation clear pulse, configured level, width
// (R15) timer start clears count, counts to limit
// (R16) repeat bit restarts timer after expiry
// (R17) timer stop halts and zeroes count
// (R18) split start sets active, pulses while driving
// (R19) split end finishes active pulse width
// (R20) held drive waits for release, simultaneous
// (R21) status clear zeroes error and finish bits
// (R22) page commands select page, bit 15 shows
// (R23) upper nibble opcode, low nibble set mask
// (R24) command upper byte is axis mask
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
module mmcd_decoder (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [mmcd_pkg::AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire mmcd_pkg::mmcd_axis_in_t [mmcd_pkg::NAX-1:0] axis_i,
  output mmcd_pkg::mmcd_axis_out_t [mmcd_pkg::NAX-1:0] axis_o
);

  mmcd_pkg::mmcd_state_t s_q;
  mmcd_pkg::mmcd_state_t s_d;

  logic [mmcd_pkg::NAX-1:0] tmr_start;
  logic [mmcd_pkg::NAX-1:0] tmr_stop;
  logic [mmcd_pkg::NAX-1:0] tmr_run;
  logic [mmcd_pkg::NAX-1:0] tmr_up;
  logic [mmcd_pkg::NAX-1:0][mmcd_pkg::TW-1:0] tmr_cnt;

  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // low-nibble mask when code carries the given sync opcode, zero otherwise
  function automatic logic [3:0] sync_mask(input logic [7:0] code,
                                           input logic [3:0] op);
    return (code[7:4] == op) ? code[3:0] : 4'h0; // (R23)
  endfunction : sync_mask

  // ----------
  // next state
  // ----------
  logic take;
  logic cmd_wr;
  logic [7:0] code;
  logic [mmcd_pkg::NAX-1:0] amask;
  logic release_all;
  logic [31:0] rd;
  mmcd_pkg::mmcd_axstate_t a;
  mmcd_pkg::mmcd_axstate_t sel;

  always_comb begin
    s_d = s_q;
    take = (avs_read_i || avs_write_i) && s_q.wait_q;
    cmd_wr = take && avs_write_i && (avs_address_i == mmcd_pkg::OFF_CMD);
    code = avs_writedata_i[7:0];
    amask = cmd_wr
      ? avs_writedata_i[mmcd_pkg::CMD_AXIS_LSB +: mmcd_pkg::NAX]
      : '0; // (R24)
    release_all = 1'b0;
    tmr_start = '0;
    tmr_stop = '0;
    for (int i = 0; i < mmcd_pkg::NAX; i++) begin
      if (amask[i] && code == mmcd_pkg::CMD_RELEASE) begin
        release_all = 1'b1;
      end
    end

    // bus handshake: one wait cycle, then readdata stands with wait low
    s_d.wait_q = 1'b1;
    if (take) begin
      s_d.wait_q = 1'b0;
    end

    // configuration writes
    if (take && avs_write_i) begin
      unique case (avs_address_i)
        mmcd_pkg::OFF_CFG: begin
          s_d.cfg = be_merge(s_q.cfg, avs_writedata_i, avs_byteenable_i);
        end
        mmcd_pkg::OFF_STEP: begin
          s_d.step = mmcd_pkg::SPW'(be_merge(32'(s_q.step),
                                   avs_writedata_i, avs_byteenable_i));
        end
        mmcd_pkg::OFF_TLIM: begin
          s_d.tlim = be_merge(s_q.tlim, avs_writedata_i, avs_byteenable_i);
        end
        mmcd_pkg::OFF_DCC: begin
          s_d.dcc_cfg = be_merge(s_q.dcc_cfg, avs_writedata_i,
                                 avs_byteenable_i);
        end
        mmcd_pkg::OFF_SPLIT: begin
          s_d.spl_cfg = be_merge(s_q.spl_cfg, avs_writedata_i,
                                 avs_byteenable_i);
        end
        mmcd_pkg::OFF_AXSEL: begin
          if (avs_byteenable_i[0]) begin
            s_d.axsel = avs_writedata_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // per-axis execution
    for (int i = 0; i < mmcd_pkg::NAX; i++) begin
      a = s_q.ax[i];

      // synchronous action sets
      if (amask[i]) begin
        a.sync_en = a.sync_en & ~sync_mask(code, mmcd_pkg::OP_SYNC_DIS); // (R1)
        if (!(s_q.cfg[mmcd_pkg::CFG_ERROR_SYNC_DISABLE_BIT_BIT] && s_q.ax[i].err)) begin
          a.sync_en = a.sync_en | sync_mask(code, mmcd_pkg::OP_SYNC_EN); // (R7)
        end
      end
      a.fire = s_q.ax[i].sync_en
        & ((amask[i] ? sync_mask(code, mmcd_pkg::OP_SYNC_ACT) : 4'h0) // (R5)
           | axis_i[i].sync_factor); // (R2)

      // error and finish status, event wins over clear
      if (amask[i] && code == mmcd_pkg::CMD_STS_CLR) begin
        a.err = 1'b0; // (R21)
        a.info = '0;
        a.fin = '0;
      end
      if (axis_i[i].err_evt) begin
        a.err = 1'b1;
        a.info = a.info | axis_i[i].err_info;
      end
      if (axis_i[i].fin_evt) begin
        a.fin = a.fin | axis_i[i].fin_code;
      end

      // status page
      if (amask[i] && code == mmcd_pkg::CMD_PAGE0) begin
        a.page = 1'b0; // (R22)
      end
      if (amask[i] && code == mmcd_pkg::CMD_PAGE1) begin
        a.page = 1'b1; // (R22)
      end

      // drive start hold
      a.start = 1'b0;
      if (amask[i] && code == mmcd_pkg::CMD_HOLD) begin
        a.hold = 1'b1;
      end
      if (axis_i[i].drive_req) begin
        if (a.hold) begin
          a.pend = 1'b1; // (R20)
        end else begin
          a.start = 1'b1;
        end
      end
      if (release_all) begin
        a.hold = 1'b0; // (R20)
        if (a.pend) begin
          a.start = 1'b1;
          a.pend = 1'b0;
        end
      end

      // running speed, loaded from the setting at each start
      if (s_q.ax[i].start) begin
        a.speed = axis_i[i].drive_speed;
      end else if (amask[i] && axis_i[i].driving && !axis_i[i].interp
                   && axis_i[i].constant_speed_flag) begin // (R11)
        if (code == mmcd_pkg::CMD_SPD_UP) begin
          a.speed = s_q.ax[i].speed + s_q.step; // (R9)
        end else if (code == mmcd_pkg::CMD_SPD_DN) begin
          a.speed = (s_q.ax[i].speed > s_q.step)
            ? s_q.ax[i].speed - s_q.step : '0; // (R10)
        end
      end // (R12)

      // deviation clear pulse
      if (amask[i] && code == mmcd_pkg::CMD_DCC) begin
        a.dcc_on = 1'b1; // (R14)
        a.dcc_cnt = s_q.dcc_cfg[mmcd_pkg::PW-1:0];
      end else if (s_q.ax[i].dcc_on) begin
        if (s_q.ax[i].dcc_cnt <= 16'h0001) begin
          a.dcc_on = 1'b0;
          a.dcc_cnt = '0;
        end else begin
          a.dcc_cnt = s_q.ax[i].dcc_cnt - 1'b1;
        end
      end

      // timer control strobes
      tmr_start[i] = amask[i] && code == mmcd_pkg::CMD_TMR_START; // (R15)
      tmr_stop[i] = amask[i] && code == mmcd_pkg::CMD_TMR_STOP; // (R17)

      // split pulse: active for the low field, period in the high field
      if (amask[i] && code == mmcd_pkg::CMD_SPL_START) begin
        a.split_act = 1'b1; // (R18)
      end
      if (amask[i] && code == mmcd_pkg::CMD_SPL_END) begin
        a.split_act = 1'b0; // (R19)
      end
      if ((s_q.ax[i].split_act && axis_i[i].driving)
          || s_q.ax[i].spl_pin) begin // (R19)
        if (s_q.ax[i].spl_cnt + 1'b1 >= s_q.spl_cfg[31:16]) begin
          a.spl_cnt = '0;
        end else begin
          a.spl_cnt = s_q.ax[i].spl_cnt + 1'b1;
        end
        a.spl_pin = (a.spl_cnt < s_q.spl_cfg[mmcd_pkg::PW-1:0])
          && (a.spl_cnt != '0 || (s_q.ax[i].split_act
                                  && axis_i[i].driving)); // (R18)
      end else begin
        a.spl_cnt = '0;
        a.spl_pin = 1'b0;
      end

      s_d.ax[i] = a;
    end

    // read data; axis registers for the selected axis, main status for all axes
    sel = s_q.ax[s_q.axsel];
    rd = '0;
    unique case (avs_address_i)
      mmcd_pkg::OFF_CFG: rd = s_q.cfg;
      mmcd_pkg::OFF_STEP: rd = 32'(s_q.step);
      mmcd_pkg::OFF_TLIM: rd = s_q.tlim;
      mmcd_pkg::OFF_DCC: rd = s_q.dcc_cfg;
      mmcd_pkg::OFF_SPLIT: rd = s_q.spl_cfg;
      mmcd_pkg::OFF_AXSEL: rd = 32'(s_q.axsel);
      mmcd_pkg::OFF_MAIN: begin
        for (int i = 0; i < mmcd_pkg::NAX; i++) begin
          rd[mmcd_pkg::MAIN_ERR_LSB + i] = s_q.ax[i].err;
        end
      end
      mmcd_pkg::OFF_ERRFIN: begin
        rd[7:0] = sel.info;
        rd[mmcd_pkg::EF_FIN_LSB +: 4] = sel.fin;
      end
      mmcd_pkg::OFF_PAGED: begin
        rd[mmcd_pkg::PG_PAGE_BIT] = sel.page; // (R22)
        if (sel.page) begin
          rd[mmcd_pkg::NSYNC-1:0] = sel.sync_en; // (R4)
          rd[mmcd_pkg::PG_SPLIT_BIT] = sel.split_act;
          rd[mmcd_pkg::PG_CONSTANT_SPEED_FLAG_BIT] = axis_i[s_q.axsel].constant_speed_flag;
        end else begin
          rd[mmcd_pkg::PG0_TRUN_BIT] = tmr_run[s_q.axsel];
        end
      end
      mmcd_pkg::OFF_SPEED: rd = 32'(sel.speed);
      mmcd_pkg::OFF_TCNT: rd = tmr_cnt[s_q.axsel];
      default: rd = '0;
    endcase
    if (take && avs_read_i) begin
      s_d.rdata = rd;
    end
  end

  // ----------
  // state register
  // ----------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0; // (R3)
      s_q.cfg <= mmcd_pkg::CFG_RST;
      s_q.step <= mmcd_pkg::STEP_RST;
      s_q.tlim <= mmcd_pkg::TLIM_RST;
      s_q.dcc_cfg <= mmcd_pkg::DCC_RST;
      s_q.spl_cfg <= mmcd_pkg::SPLIT_RST;
      s_q.wait_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------
  // timers
  // ----------
  for (genvar g = 0; g < mmcd_pkg::NAX; g++) begin : g_tmr
    mmcd_timer #(
      .TW(mmcd_pkg::TW)
    ) u_tmr (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .start_i(tmr_start[g]),
      .stop_i(tmr_stop[g]),
      .repeat_i(s_q.cfg[mmcd_pkg::CFG_TIMER_REPEAT_BIT_BIT]),
      .limit_i(s_q.tlim),
      .count_o(tmr_cnt[g]),
      .running_o(tmr_run[g]),
      .up_o(tmr_up[g])
    );
  end

  // ----------
  // outputs
  // ----------
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.wait_q;

  always_comb begin
    for (int i = 0; i < mmcd_pkg::NAX; i++) begin
      axis_o[i].sync_fire = s_q.ax[i].fire;
      axis_o[i].drive_start = s_q.ax[i].start;
      axis_o[i].speed = s_q.ax[i].speed;
      axis_o[i].dcc_pin = s_q.ax[i].dcc_on
        ~^ s_q.dcc_cfg[mmcd_pkg::DCC_LEVEL_BIT]; // (R14)
      axis_o[i].split_pin = s_q.ax[i].spl_pin;
      axis_o[i].timer_up = tmr_up[i];
    end
  end

endmodule : mmcd_decoder

// ==== tb/mmcd_checker.sv ====
// concurrent checks on the command decoder ports, bound into the decoder
// assumes config registers are written with all byte lanes enabled
`timescale 1ns/1ns
module mmcd_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [mmcd_pkg::AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire mmcd_pkg::mmcd_axis_in_t [mmcd_pkg::NAX-1:0] axis_i,
  input wire mmcd_pkg::mmcd_axis_out_t [mmcd_pkg::NAX-1:0] axis_o
);
  // ----------
  // shadow of the few settings the checks depend on
  // ----------
  logic take;
  logic wcmd;
  logic cmd0;
  logic act;
  logic rel;
  logic [7:0] code;
  logic [3:0] cause0;
  logic [3:0] cause1;
  logic lvl_q;
  logic hold_q;
  logic [mmcd_pkg::SPW-1:0] step_q;
  assign take = avs_write_i && avs_waitrequest_o;
  assign wcmd = take && avs_address_i == mmcd_pkg::OFF_CMD;
  assign code = avs_writedata_i[7:0];
  assign cmd0 = wcmd && avs_writedata_i[8];
  assign act = code[7:4] == mmcd_pkg::OP_SYNC_ACT;
  assign rel = wcmd && code == mmcd_pkg::CMD_RELEASE;
  assign cause0 = (cmd0 && act ? code[3:0] : 4'h0) | axis_i[0].sync_factor;
  assign cause1 = (wcmd && avs_writedata_i[9] && act ? code[3:0] : 4'h0)
                  | axis_i[1].sync_factor;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_q <= 1'b0;
      hold_q <= 1'b0;
      step_q <= mmcd_pkg::STEP_RST;
    end else begin
      if (take && avs_address_i == mmcd_pkg::OFF_DCC)
        lvl_q <= avs_writedata_i[mmcd_pkg::DCC_LEVEL_BIT];
      if (take && avs_address_i == mmcd_pkg::OFF_STEP)
        step_q <= avs_writedata_i[mmcd_pkg::SPW-1:0];
      if (cmd0 && code == mmcd_pkg::CMD_HOLD)
        hold_q <= 1'b1;
      else if (rel)
        hold_q <= 1'b0;
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_spd0(logic [7:0] c);
    cmd0 && code == c && axis_i[0].driving && axis_i[0].constant_speed_flag
    && !axis_i[0].interp;
  endsequence
  sequence s_quiet;
    !axis_o[0].timer_up [*8];
  endsequence
  property p_wait;
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o;
  endproperty
  property p_fire0;
    (axis_o[0].sync_fire & ~$past(cause0)) == 4'h0;
  endproperty
  property p_fire1;
    (axis_o[1].sync_fire & ~$past(cause1)) == 4'h0;
  endproperty
  property p_dcc;
    cmd0 && code == mmcd_pkg::CMD_DCC |=> axis_o[0].dcc_pin == lvl_q;
  endproperty
  property p_hold;
    hold_q && axis_i[0].drive_req && !rel |=> !axis_o[0].drive_start;
  endproperty
  property p_spd_up;
    s_spd0(mmcd_pkg::CMD_SPD_UP) |=>
      axis_o[0].speed == $past(axis_o[0].speed) + $past(step_q);
  endproperty
  property p_spd_dn;
    s_spd0(mmcd_pkg::CMD_SPD_DN) |=> axis_o[0].speed ==
      ($past(axis_o[0].speed) >= $past(step_q) ?
       $past(axis_o[0].speed) - $past(step_q) : '0);
  endproperty
  property p_spd_keep;
    cmd0 && code[7:1] == 7'h38 && (!axis_i[0].constant_speed_flag || axis_i[0].interp)
    |=> $stable(axis_o[0].speed);
  endproperty
  property p_tmr_stop;
    cmd0 && code == mmcd_pkg::CMD_TMR_STOP |-> ##4 s_quiet;
  endproperty
  a_wait: assert property (p_wait)
    else $error("waitrequest low for more than one cycle");
  a_fire0: assert property (p_fire0)
    else $error("axis 0 set fired without activation");
  a_fire1: assert property (p_fire1)
    else $error("axis 1 set fired without its mask bit");
  a_dcc: assert property (p_dcc)
    else $error("deviation clear pin not at configured level");
  a_hold: assert property (p_hold)
    else $error("held axis started before release");
  a_spd_up: assert property (p_spd_up)
    else $error("speed increase wrong");
  a_spd_dn: assert property (p_spd_dn)
    else $error("speed decrease wrong");
  a_spd_keep: assert property (p_spd_keep)
    else $error("speed changed outside constant speed");
  a_tmr_stop: assert property (p_tmr_stop)
    else $error("timer expired after stop");
endmodule : mmcd_checker

bind mmcd_decoder mmcd_checker u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .axis_i(axis_i), .axis_o(axis_o)
);

// ==== tb/mmcd_host.sv ====
// host processor model issuing avalon-mm register accesses
// assumes the slave answers by dropping waitrequest for one cycle
`timescale 1ns/1ns
module mmcd_host (
  input wire logic mclk_i,
  input wire logic waitreq_i,
  input wire logic [31:0] rdata_i,
  output logic [mmcd_pkg::AW-1:0] addr_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] wdata_o,
  output logic [3:0] be_o
);
  initial begin
    addr_o = '0;
    read_o = 1'b0;
    write_o = 1'b0;
    wdata_o = 32'h0;
    be_o = 4'hf;
  end
  task wr(input logic [mmcd_pkg::AW-1:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    write_o <= 1'b1;
    @(posedge mclk_i);
    while (waitreq_i !== 1'b0) @(posedge mclk_i);
    write_o <= 1'b0;
  endtask : wr
  task rd(input logic [mmcd_pkg::AW-1:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    read_o <= 1'b1;
    @(posedge mclk_i);
    while (waitreq_i !== 1'b0) @(posedge mclk_i);
    d = rdata_i;
    read_o <= 1'b0;
  endtask : rd
endmodule : mmcd_host

// ==== tb/testbench.sv ====
// self-checking bench for the command decoder
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ns
module testbench;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [mmcd_pkg::AW-1:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic waitreq;
  logic [31:0] v;
  int n;
  int n_errors = 0;
  int num_checks = 0;
  mmcd_pkg::mmcd_axis_in_t [mmcd_pkg::NAX-1:0] ax_in;
  mmcd_pkg::mmcd_axis_out_t [mmcd_pkg::NAX-1:0] ax_o;
  mmcd_pkg::mmcd_axis_out_t [mmcd_pkg::NAX-1:0] snap;
  logic [7:0] sc [5] = '{8'h70, 8'h71, 8'h71, 8'h70, 8'h70};
  logic cn [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic ip [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [31:0] se [5] = '{32'd105, 32'd100, 32'd95, 32'd95, 32'd95};
  always #2 mclk_i = ~mclk_i;
  mmcd_host host (.mclk_i(mclk_i), .waitreq_i(waitreq), .rdata_i(rdata),
    .addr_o(addr), .read_o(rd), .write_o(wr), .wdata_o(wdata), .be_o(be));
  mmcd_decoder dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .axis_i(ax_in), .axis_o(ax_o));
  // ----------
  // helpers
  // ----------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task cmd(input logic [3:0] m, input logic [7:0] c);
    host.wr(mmcd_pkg::OFF_CMD, {20'h0, m, c});
    snap = ax_o;
  endtask : cmd
  task rchk(input string nm, input logic [5:0] a, input logic [31:0] m,
            input logic [31:0] e);
    host.rd(a, v);
    chk(nm, e, v & m);
  endtask : rchk
  task pulse_len(input bit s, input logic lvl, output int w);
    w = 0;
    while ((s ? ax_o[0].split_pin : ax_o[0].dcc_pin) === lvl && w < 99) begin
      w++;
      @(posedge mclk_i);
    end
  endtask : pulse_len
  task wait_up;
    n = 0;
    @(posedge mclk_i);
    while (ax_o[0].timer_up !== 1'b1 && n < 40) begin
      n++;
      @(posedge mclk_i);
    end
    chk("timer_up", 32'h1, {31'h0, ax_o[0].timer_up});
  endtask : wait_up
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_errors++;
    tally_and_finish();
  end
  // ----------
  // tests
  // ----------
  initial begin
    ax_in = '0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    host.wr(mmcd_pkg::OFF_AXSEL, 32'h0);
    cmd(4'h1, mmcd_pkg::CMD_PAGE1);
    rchk("page1", mmcd_pkg::OFF_PAGED, 32'h800f, 32'h8000);
    cmd(4'h1, mmcd_pkg::CMD_PAGE0);
    rchk("page0", mmcd_pkg::OFF_PAGED, 32'h8000, 32'h0);
    cmd(4'h1, {mmcd_pkg::OP_SYNC_EN, 4'hf});
    cmd(4'h2, {mmcd_pkg::OP_SYNC_EN, 4'hf});
    cmd(4'h1, {mmcd_pkg::OP_SYNC_DIS, 4'ha});
    cmd(4'h1, mmcd_pkg::CMD_PAGE1);
    rchk("sync_en", mmcd_pkg::OFF_PAGED, 32'hf, 32'h5);
    cmd(4'h1, {mmcd_pkg::OP_SYNC_ACT, 4'hf});
    chk("fire0", 32'h5, {28'h0, snap[0].sync_fire});
    chk("fire1", 32'h0, {28'h0, snap[1].sync_fire});
    ax_in[0].sync_factor <= 4'hf;
    @(posedge mclk_i);
    ax_in[0].sync_factor <= 4'h0;
    @(posedge mclk_i);
    chk("factor", 32'h5, {28'h0, ax_o[0].sync_fire});
    host.wr(mmcd_pkg::OFF_CFG, 32'h80);
    cmd(4'h1, {mmcd_pkg::OP_SYNC_DIS, 4'hf});
    ax_in[0].err_evt <= 1'b1;
    ax_in[0].err_info <= 8'h3c;
    ax_in[0].fin_evt <= 1'b1;
    ax_in[0].fin_code <= 4'h2;
    @(posedge mclk_i);
    ax_in[0].err_evt <= 1'b0;
    ax_in[0].fin_evt <= 1'b0;
    rchk("main", mmcd_pkg::OFF_MAIN, 32'hf0, 32'h10);
    rchk("errfin", mmcd_pkg::OFF_ERRFIN, 32'hfff, 32'h23c);
    cmd(4'h1, {mmcd_pkg::OP_SYNC_EN, 4'h1});
    rchk("refused", mmcd_pkg::OFF_PAGED, 32'hf, 32'h0);
    cmd(4'h1, mmcd_pkg::CMD_STS_CLR);
    rchk("main_clr", mmcd_pkg::OFF_MAIN, 32'hf0, 32'h0);
    rchk("errfin_clr", mmcd_pkg::OFF_ERRFIN, 32'hfff, 32'h0);
    cmd(4'h1, {mmcd_pkg::OP_SYNC_EN, 4'h1});
    rchk("accepted", mmcd_pkg::OFF_PAGED, 32'hf, 32'h1);
    host.wr(mmcd_pkg::OFF_CFG, 32'h2000);
    host.wr(mmcd_pkg::OFF_STEP, 32'h5);
    ax_in[0].driving <= 1'b1;
    ax_in[0].constant_speed_flag <= 1'b1;
    ax_in[0].drive_speed <= 24'h000064;
    ax_in[0].drive_req <= 1'b1;
    @(posedge mclk_i);
    ax_in[0].drive_req <= 1'b0;
    @(posedge mclk_i);
    chk("start", 32'h1, {31'h0, ax_o[0].drive_start});
    rchk("speed", mmcd_pkg::OFF_SPEED, 32'hffffff, 32'd100);
    for (int i = 0; i < 5; i++) begin
      ax_in[0].constant_speed_flag <= cn[i];
      ax_in[0].interp <= ip[i];
      cmd(4'h1, sc[i]);
      rchk("speed", mmcd_pkg::OFF_SPEED, 32'hffffff, se[i]);
    end
    ax_in[0].interp <= 1'b0;
    cmd(4'h3, mmcd_pkg::CMD_HOLD);
    ax_in[0].drive_req <= 1'b1;
    ax_in[1].drive_req <= 1'b1;
    @(posedge mclk_i);
    ax_in[0].drive_req <= 1'b0;
    ax_in[1].drive_req <= 1'b0;
    repeat (4) begin
      @(posedge mclk_i);
      chk("held", 32'h0, {ax_o[1].drive_start, ax_o[0].drive_start});
    end
    cmd(4'h4, mmcd_pkg::CMD_RELEASE);
    chk("release", 32'h3, {snap[1].drive_start, snap[0].drive_start});
    cmd(4'h1, mmcd_pkg::CMD_DCC);
    pulse_len(1'b0, 1'b0, n);
    chk("dcc_low", {16'h0, mmcd_pkg::DCC_RST[15:0]}, n);
    host.wr(mmcd_pkg::OFF_DCC, 32'h0001_0003);
    cmd(4'h1, mmcd_pkg::CMD_DCC);
    pulse_len(1'b0, 1'b1, n);
    chk("dcc_high", 32'h3, n);
    host.wr(mmcd_pkg::OFF_TLIM, 32'd10);
    cmd(4'h1, mmcd_pkg::CMD_TMR_START);
    cmd(4'h1, mmcd_pkg::CMD_PAGE0);
    rchk("running", mmcd_pkg::OFF_PAGED, 32'h1, 32'h1);
    wait_up();
    rchk("oneshot", mmcd_pkg::OFF_PAGED, 32'h1, 32'h0);
    host.wr(mmcd_pkg::OFF_CFG, 32'h4000);
    cmd(4'h1, mmcd_pkg::CMD_TMR_START);
    wait_up();
    wait_up();
    cmd(4'h1, mmcd_pkg::CMD_TMR_STOP);
    rchk("tcnt", mmcd_pkg::OFF_TCNT, 32'hffffffff, 32'h0);
    rchk("stopped", mmcd_pkg::OFF_PAGED, 32'h1, 32'h0);
    cmd(4'h1, mmcd_pkg::CMD_SPL_START);
    cmd(4'h1, mmcd_pkg::CMD_PAGE1);
    rchk("split_on", mmcd_pkg::OFF_PAGED, 32'h10, 32'h10);
    pulse_len(1'b1, 1'b1, n);
    n = 0;
    while (ax_o[0].split_pin !== 1'b1 && n < 40) begin
      n++;
      @(posedge mclk_i);
    end
    chk("split_pin", 32'h1, {31'h0, ax_o[0].split_pin});
    fork
      cmd(4'h1, mmcd_pkg::CMD_SPL_END);
      pulse_len(1'b1, 1'b1, n);
    join
    chk("split_w", {16'h0, mmcd_pkg::SPLIT_RST[15:0]}, n);
    rchk("split_off", mmcd_pkg::OFF_PAGED, 32'h10, 32'h0);
    tally_and_finish();
  end
endmodule : testbench
